// *** deg_driver_enable.sv ***
`timescale 1ns/1ps
module deg_driver_enable
    import deg_pkg::*;
#(
    parameter int N_HS = NUM_HS,
    parameter int N_LS = NUM_LS
)(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              drive_permit,
    input  wire logic              vccp_undervolt,
    input  wire logic              logic_supply_low,
    input  wire logic              boost_supply_low,
    input  wire logic              ground_loss,
    input  wire logic              over_temp,
    input  wire logic              clock_missing,
    input  wire logic              clock_loss_shutdown_en,
    input  wire logic              boost_disable_en,
    input  wire logic              low_side_seven_bypass,
    input  wire logic              dedicated_outputs_bypass,
    input  wire logic              clear_on_read_en,
    input  wire logic [ADDR_W-1:0] spi_addr,
    input  wire logic              spi_wr_stb,
    input  wire logic              spi_rd_stb,
    output logic      [DATA_W-1:0] spi_rdata,
    output logic      [N_HS-1:0]   high_side_gate_enable,
    output logic      [N_LS-1:0]   low_side_gate_enable
);
    // ************************************************************
    // Parameter check
    // ************************************************************
    generate
        if (N_HS != NUM_HS || N_LS != NUM_LS) begin : g_bad
            $error("deg_driver_enable supports five high-side and seven low-side drivers");
        end
    endgenerate

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    logic [NUM_SYNC-1:0] raw_in;
    logic [NUM_SYNC-1:0] syn;
    wire                 permit_s;
    wire                 vccp_s;
    wire                 vcc5_s;
    wire                 boost_s;
    wire                 gnd_s;
    wire                 otemp_s;
    wire                 missing_s;

    assign raw_in = {clock_missing, over_temp, ground_loss, boost_supply_low,
                     logic_supply_low, vccp_undervolt, drive_permit};

    deg_sync #(
        .WIDTH    (NUM_SYNC)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (raw_in),
        .sync_out (syn)
    );

    assign permit_s  = syn[0];
    assign vccp_s    = syn[1];
    assign vcc5_s    = syn[2];
    assign boost_s   = syn[3];
    assign gnd_s     = syn[4];
    assign otemp_s   = syn[5];
    assign missing_s = syn[6];

    // ************************************************************
    // Enable gating
    // ************************************************************
    function automatic logic gate_fn(input logic base, input logic permit,
                                     input logic bypass);
        gate_fn = base & (permit | bypass);
    endfunction : gate_fn

    wire                 clock_ok;
    wire                 supply_ok;
    wire                 base_ok;
    wire                 boost_ok;
    logic [N_HS-1:0]     nxt_hs;
    logic [N_LS-1:0]     nxt_ls;
    logic [N_HS-1:0]     hs_ff;
    logic [N_LS-1:0]     ls_ff;

    assign clock_ok  = ~(clock_loss_shutdown_en & missing_s);
    assign supply_ok = ~(vccp_s | gnd_s) & ~vcc5_s;
    assign base_ok   = supply_ok & clock_ok;
    assign boost_ok  = ~(boost_disable_en & boost_s);

    genvar gi;
    generate
        for (gi = 0; gi < N_LS; gi++) begin : g_ls
            if (gi == 6) begin : g_seven
                assign nxt_ls[gi] = gate_fn(base_ok, permit_s, low_side_seven_bypass);
            end else if (gi == 2 || gi == 5) begin : g_ded
                assign nxt_ls[gi] = gate_fn(base_ok, permit_s, dedicated_outputs_bypass);
            end else begin : g_std
                assign nxt_ls[gi] = gate_fn(base_ok, permit_s, 1'b0);
            end
        end
        for (gi = 0; gi < N_HS; gi++) begin : g_hs
            if (gi == 4) begin : g_ded
                assign nxt_hs[gi] = gate_fn(base_ok & boost_ok, permit_s,
                                            dedicated_outputs_bypass);
            end else begin : g_std
                assign nxt_hs[gi] = gate_fn(base_ok & boost_ok, permit_s, 1'b0);
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hs_ff <= '0;
            ls_ff <= '0;
        end else begin
            hs_ff <= nxt_hs;
            ls_ff <= nxt_ls;
        end
    end

    assign high_side_gate_enable = hs_ff;
    assign low_side_gate_enable  = ls_ff;

    // ************************************************************
    // Status flags
    // ************************************************************
    wire                 sel_status;
    wire                 clr_stb;
    logic [STAT_W-1:0]   err_vec;
    logic [STAT_W-1:0]   flags;
    logic [STAT_W-1:0]   status_view;
    logic [DATA_W-1:0]   rdata_ff;
    logic [DATA_W-1:0]   nxt_rdata;

    assign sel_status = (spi_addr == DRIVE_FAULT_STATUS);
    assign clr_stb    = sel_status & (spi_wr_stb | (spi_rd_stb & clear_on_read_en));

    assign err_vec[BIT_VCCP]        = vccp_s | gnd_s;
    assign err_vec[BIT_VCC5]        = vcc5_s;
    assign err_vec[BIT_BOOST]       = boost_s & boost_disable_en;
    assign err_vec[BIT_OTEMP]       = otemp_s;
    assign err_vec[BIT_PERMIT_LIVE] = 1'b0;
    assign err_vec[BIT_PERMIT_SEEN] = ~permit_s;
    assign err_vec[BIT_CLK_LOST]    = missing_s & clock_loss_shutdown_en;

    deg_flag_bank #(
        .WIDTH   (STAT_W)
    ) u_flags (
        .sys_clk (sys_clk),
        .reset   (reset),
        .err_set (err_vec),
        .clear   (clr_stb),
        .flags   (flags)
    );

    assign status_view = {flags[BIT_CLK_LOST], ~flags[BIT_PERMIT_SEEN], permit_s,
                          flags[BIT_OTEMP:BIT_VCCP]};
    assign nxt_rdata   = sel_status ? {{(DATA_W-STAT_W){1'b0}}, status_view} : '0;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= '0;
        end else if (spi_rd_stb) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign spi_rdata = rdata_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_clear_idle;
        clr_stb && !err_vec[BIT_VCC5];
    endsequence

    a_ls_needs_permit: assert property (!permit_s && !dedicated_outputs_bypass |=>
        !low_side_gate_enable[0] && !low_side_gate_enable[5])
        else $error("low side enabled without permit");
    a_ls7_bypass_on: assert property (base_ok && low_side_seven_bypass |=>
        low_side_gate_enable[6])
        else $error("low side seven not bypassing permit");
    a_hs_boost_gate: assert property (boost_s && boost_disable_en |=>
        high_side_gate_enable == '0)
        else $error("high side enabled under boost undervoltage");
    a_clock_loss_off: assert property (missing_s && clock_loss_shutdown_en |=>
        low_side_gate_enable == '0 && high_side_gate_enable == '0)
        else $error("drivers on while clock missing");
    a_otemp_no_gate: assert property (otemp_s && permit_s && supply_ok && clock_ok && boost_ok
        |=> high_side_gate_enable == '1)
        else $error("overtemperature disabled drivers");
    a_boost_flag_cond: assert property ($rose(flags[BIT_BOOST]) |->
        $past(boost_s) && $past(boost_disable_en))
        else $error("boost flag set without disabling");
    a_flag_holds: assert property (flags[BIT_VCC5] && !clr_stb |=> flags[BIT_VCC5])
        else $error("flag lost without clear");
    a_set_wins: assert property (clr_stb && vcc5_s |=> flags[BIT_VCC5])
        else $error("clear beat active error");
    a_clear_works: assert property (s_clear_idle |=> !flags[BIT_VCC5])
        else $error("flag not cleared");
    a_read_no_clear: assert property (spi_rd_stb && !spi_wr_stb && !clear_on_read_en
        && flags[BIT_VCCP] |=> flags[BIT_VCCP])
        else $error("read cleared flag while disabled");
    a_permit_seen: assert property (!permit_s |=> !status_view[BIT_PERMIT_SEEN])
        else $error("permit seen not cleared");
    a_read_live: assert property (spi_rd_stb && sel_status |=>
        spi_rdata[BIT_PERMIT_LIVE] == $past(permit_s))
        else $error("live permit bit wrong");
endmodule : deg_driver_enable

// *** deg_pkg.sv ***
// Operation
// - Low-side drivers one to six need permit pin, both supplies good, clock gate.
// - Low-side seven needs both supplies good and clock gate; permit is configurable.
// - High-side drivers need permit, both supplies, clock gate, optional boost check.
// - Separate enable outputs for the high-side and the low-side groups.
// - Seven-bit status register latches every condition that disabled the drivers.
// - Clock-lost flag set when missing clock disabled drivers, if shutdown enabled.
// - Permit-seen bit reads 0 once permit went low since last clear, else 1.
// - Live status bit mirrors the present permit pin level.
// - Overtemperature latched in a flag but never disables a driver.
// - Boost flag set only when boost undervoltage actually disabled high-side drivers.
// - Logic-supply low in one flag; vccp undervoltage or ground loss in another.
// - Flags clear on status write or clear-on-read status read, and only when the error is gone.
// - Status read also clears flags when clear-on-read enable is set.
// - Clock shutdown bit set drops clock permit while clock-missing stays asserted.
// - Low-side seven bypass bit set makes that driver ignore the permit pin.
// - Dedicated bypass set makes high-side five, low-side three and six ignore permit.
package deg_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W              = 10;
    localparam int          DATA_W              = 16;
    localparam logic [9:0]  DRIVE_FAULT_STATUS  = 10'h1D2;
    localparam int          STAT_W              = 7;
    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int          BIT_VCCP            = 0;
    localparam int          BIT_VCC5            = 1;
    localparam int          BIT_BOOST           = 2;
    localparam int          BIT_OTEMP           = 3;
    localparam int          BIT_PERMIT_LIVE     = 4;
    localparam int          BIT_PERMIT_SEEN     = 5;
    localparam int          BIT_CLK_LOST        = 6;
    // ************************************************************
    // Reset values and sizes
    // ************************************************************
    localparam logic [6:0]  FLAGS_RESET         = 7'h00;
    localparam int          NUM_SYNC            = 7;
    localparam int          NUM_HS              = 5;
    localparam int          NUM_LS              = 7;
endpackage : deg_pkg

// *** deg_sync.sv ***
`timescale 1ns/1ps
module deg_sync
    import deg_pkg::*;
#(
    parameter int WIDTH = NUM_SYNC
)(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // ************************************************************
    // Three stages, accept when second and third agree
    // ************************************************************
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("deg_sync width must be positive");
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            out_ff <= '0;
        end else begin
            s1_ff  <= async_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
        end
    end

    assign sync_out = out_ff;
endmodule : deg_sync

// *** deg_flag_bank.sv ***
`timescale 1ns/1ps
module deg_flag_bank
    import deg_pkg::*;
#(
    parameter int WIDTH = STAT_W
)(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] err_set,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] flags
);
    // ************************************************************
    // Sticky flags, set wins over clear
    // ************************************************************
    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    assign nxt_flags = err_set | (flags_ff & ~{WIDTH{clear}});

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flags_ff <= FLAGS_RESET[WIDTH-1:0];
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule : deg_flag_bank

// *** deg_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Host side of the status access port
// ****************************************
module deg_host_model
    import deg_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [DATA_W-1:0] spi_rdata,
    output logic      [ADDR_W-1:0] spi_addr,
    output logic                   spi_wr_stb,
    output logic                   spi_rd_stb
);
    initial begin
        spi_addr   = ~DRIVE_FAULT_STATUS;
        spi_wr_stb = 1'b0;
        spi_rd_stb = 1'b0;
    end

    // One access, strobe up for one taking edge
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                          output logic [DATA_W-1:0] data);
        @(posedge sys_clk);
        spi_addr   <= addr;
        spi_wr_stb <= wr;
        spi_rd_stb <= ~wr;
        @(posedge sys_clk);
        spi_addr   <= ~addr;
        spi_wr_stb <= 1'b0;
        spi_rd_stb <= 1'b0;
        #1 data = spi_rdata;
    endtask : access
endmodule : deg_host_model

// *** driver_enable_gating_tb.sv ***
`timescale 1ns/1ps
module driver_enable_gating_tb;
    import deg_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic              sys_clk                  = 1'b0;
    logic              reset                    = 1'b1;
    logic              drive_permit             = 1'b0;
    logic              vccp_undervolt           = 1'b0;
    logic              logic_supply_low         = 1'b0;
    logic              boost_supply_low         = 1'b0;
    logic              ground_loss              = 1'b0;
    logic              over_temp                = 1'b0;
    logic              clock_missing            = 1'b0;
    logic              clock_loss_shutdown_en   = 1'b0;
    logic              boost_disable_en         = 1'b0;
    logic              low_side_seven_bypass    = 1'b0;
    logic              dedicated_outputs_bypass = 1'b0;
    logic              clear_on_read_en         = 1'b0;
    logic [ADDR_W-1:0] spi_addr;
    logic              spi_wr_stb;
    logic              spi_rd_stb;
    logic [DATA_W-1:0] spi_rdata;
    logic [NUM_HS-1:0] high_side_gate_enable;
    logic [NUM_LS-1:0] low_side_gate_enable;
    logic [DATA_W-1:0] rd;
    int                bad_count                = 0;
    int                comparisons              = 0;
    // Rows: inputs, high-side, low-side
    logic [21:0]       rows [11] = '{22'h200FFF, 22'h000000, 22'h002040, 22'h001824,
                                     22'h300000, 22'h280000, 22'h240FFF, 22'h24407F,
                                     22'h220000, 22'h210FFF, 22'h218000};

    always #20 sys_clk = ~sys_clk;

    deg_driver_enable dut_u (.sys_clk, .reset, .drive_permit, .vccp_undervolt,
        .logic_supply_low, .boost_supply_low, .ground_loss, .over_temp, .clock_missing,
        .clock_loss_shutdown_en, .boost_disable_en, .low_side_seven_bypass,
        .dedicated_outputs_bypass, .clear_on_read_en, .spi_addr, .spi_wr_stb,
        .spi_rd_stb, .spi_rdata, .high_side_gate_enable, .low_side_gate_enable);

    deg_host_model host_u (.sys_clk, .spi_rdata, .spi_addr, .spi_wr_stb, .spi_rd_stb);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apply(input logic [9:0] v);
        @(posedge sys_clk);
        {drive_permit, vccp_undervolt, logic_supply_low, boost_supply_low, ground_loss,
         clock_missing, clock_loss_shutdown_en, boost_disable_en, low_side_seven_bypass,
         dedicated_outputs_bypass} <= v;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask : apply

    task automatic check_en(input logic [4:0] hs, input logic [6:0] ls);
        check("high_side", {11'h000, high_side_gate_enable}, {11'h000, hs});
        check("low_side", {9'h000, low_side_gate_enable}, {9'h000, ls});
    endtask : check_en

    task automatic rd_stat(input logic [6:0] exp);
        host_u.access(1'b0, DRIVE_FAULT_STATUS, rd);
        check("status", rd, {9'h000, exp});
    endtask : rd_stat

    task automatic wr_stat();
        host_u.access(1'b1, DRIVE_FAULT_STATUS, rd);
    endtask : wr_stat

    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        @(posedge sys_clk);
        #1 check_en(5'h00, 7'h00);
        check("rdata_reset", spi_rdata, 16'h0000);
        @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            apply(rows[i][21:12]);
            check_en(rows[i][11:7], rows[i][6:0]);
        end
        apply(10'h200);
        @(posedge sys_clk);
        drive_permit <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 check_en(5'h1F, 7'h7F);
        apply(10'h200);
        rd_stat(7'h57);
        rd_stat(7'h57);
        wr_stat();
        rd_stat(7'h30);
        apply(10'h280);
        wr_stat();
        rd_stat(7'h32);
        apply(10'h250);
        host_u.access(1'b1, 10'h1D3, rd);
        rd_stat(7'h32);
        wr_stat();
        rd_stat(7'h30);
        @(posedge sys_clk);
        over_temp <= 1'b1;
        apply(10'h200);
        check_en(5'h1F, 7'h7F);
        @(posedge sys_clk);
        over_temp <= 1'b0;
        clear_on_read_en <= 1'b1;
        apply(10'h200);
        rd_stat(7'h38);
        rd_stat(7'h30);
        apply(10'h000);
        check_en(5'h00, 7'h00);
        rd_stat(7'h00);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        #1 check_en(5'h00, 7'h00);
        check("rdata_mid_reset", spi_rdata, 16'h0000);
        @(posedge sys_clk);
        reset <= 1'b0;
        apply(10'h200);
        rd_stat(7'h10);
        host_u.access(1'b0, 10'h1D3, rd);
        check("unmapped", rd, 16'h0000);
        report_and_stop();
    end

    // Watchdog, roughly 47 times the expected run
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
endmodule : driver_enable_gating_tb
